//--- rtl/dgo_output_cond.sv
/*
  Digital output conditioning for the multifunction output terminals of a
  motor drive: source selection, on and off delays, contact polarity,
  state readback and a change interrupt, behind an Avalon-MM slave.
  Register map, one 32-bit word each, fields in the low bits:
    0x00 terminal states, read only
    0x04 change status, read only, one sticky bit per terminal
    0x08 change clear, write only, a one clears that bit
    0x0c change interrupt enable
    0x10 target bound limit, 0x14 tracking error limit
    0x20 + 0x10 * n, terminal n: +0 source select, +4 on delay,
    +8 off delay, +c contact polarity in bit 0
  Assumes condition flags come from logic on the same clock, except the
  external supply presence, which is a pin and is synchronised here.
  Selection 0 and the codes not handled here hold the condition low, so
  such a terminal shows its contact polarity alone.
*/
// Decided for this implementation: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "dgo_cfg.svh"

module dgo_output_cond #(
  parameter int NUM_OUT     = 3,
  parameter int POS_W       = 32,
  parameter int TICK_CYCLES = `DGO_TICK_CYCLES
) (
  input  wire logic                   clock,
  input  wire logic                   rst_n,
  input  wire logic [`DGO_ADDR_W-1:0] address,
  input  wire logic                   read,
  input  wire logic                   write,
  input  wire logic [31:0]            writedata,
  output logic      [31:0]            readdata,
  output logic                        waitrequest,
  output logic                        irq,
  output logic      [NUM_OUT-1:0]     terminalOut,
  input  wire logic [2:0]             analogInputLossWarn,
  input  wire logic                   externalSupplyPresence,
  input  wire logic                   capReplaceWarning,
  input  wire logic                   primaryFanReplaceWarning,
  input  wire logic                   secondaryFanReplaceWarning,
  input  wire logic                   capacitorLifeAlarm,
  input  wire logic                   positionDone,
  input  wire logic [POS_W-1:0]       targetPosition,
  input  wire logic [POS_W-1:0]       actualPosition,
  input  wire logic [POS_W-1:0]       refPulseCount,
  input  wire logic [POS_W-1:0]       feedbackPulseCount
);

  // Field widths come from the shared constants so bench and design agree.
  localparam int SEL_W = `DGO_SEL_W;
  localparam int DLY_W = `DGO_DELAY_W;
  localparam int TICK_W = $clog2(TICK_CYCLES + 1);

  // Bus slave.
  logic                   waitQ;
  logic                   accept;
  logic [31:0]            readD;
  logic [NUM_OUT-1:0]     termQ;
  logic [NUM_OUT-1:0]     irqStatusQ;
  logic [NUM_OUT-1:0]     irqEnableQ;
  logic [POS_W-1:0]       boundLimitQ;
  logic [POS_W-1:0]       trackLimitQ;
  logic [SEL_W-1:0]       selQ    [NUM_OUT];
  logic [DLY_W-1:0]       onDlyQ  [NUM_OUT];
  logic [DLY_W-1:0]       offDlyQ [NUM_OUT];
  logic [NUM_OUT-1:0]     polQ;

  // The transfer completes on the edge where waitrequest is seen low;
  // the one wait cycle gives the read mux a full period to settle.
  assign accept = (read || write) && !waitQ;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      waitQ <= 1'b1;
    end else if (accept) begin
      waitQ <= 1'b1;
    end else if (read || write) begin
      waitQ <= 1'b0;
    end
  end

  assign waitrequest = waitQ;

  always_comb begin
    // Write-only clear and unmapped words read as zero.
    readD = 32'h00000000;
    case (address)
      `DGO_OFF_STATE:       readD[NUM_OUT-1:0] = termQ;
      `DGO_OFF_IRQ_STATUS:  readD[NUM_OUT-1:0] = irqStatusQ;
      `DGO_OFF_IRQ_ENABLE:  readD[NUM_OUT-1:0] = irqEnableQ;
      `DGO_OFF_BOUND_LIMIT: readD[POS_W-1:0]   = boundLimitQ;
      `DGO_OFF_TRACK_LIMIT: readD[POS_W-1:0]   = trackLimitQ;
      default: begin
        for (int k = 0; k < NUM_OUT; k++) begin
          if (address == 8'(`DGO_TERM_BASE + k * `DGO_TERM_STRIDE
                            + `DGO_TOFF_SELECT)) begin
            readD[SEL_W-1:0] = selQ[k];
          end
          if (address == 8'(`DGO_TERM_BASE + k * `DGO_TERM_STRIDE
                            + `DGO_TOFF_ON_DELAY)) begin
            readD[DLY_W-1:0] = onDlyQ[k];
          end
          if (address == 8'(`DGO_TERM_BASE + k * `DGO_TERM_STRIDE
                            + `DGO_TOFF_OFF_DELAY)) begin
            readD[DLY_W-1:0] = offDlyQ[k];
          end
          if (address == 8'(`DGO_TERM_BASE + k * `DGO_TERM_STRIDE
                            + `DGO_TOFF_POLARITY)) begin
            readD[0] = polQ[k];
          end
        end
      end
    endcase
  end

  // The word is captured at the first edge of an access, so it stands
  // unchanged through the wait cycle and is valid when waitrequest is low.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      readdata <= 32'h00000000;
    end else if ((read || write) && waitQ) begin
      readdata <= readD;
    end
  end

  // Delay writes above the documented range are clamped, not wrapped, so
  // an oversized value cannot turn into a short delay.
  logic [DLY_W-1:0] wrDelay;

  assign wrDelay = (writedata > 32'(`DGO_DELAY_MAX_MS))
                   ? DLY_W'(`DGO_DELAY_MAX_MS) : writedata[DLY_W-1:0];

  // Shared configuration registers.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      boundLimitQ <= POS_W'(`DGO_LIMIT_RESET);
      trackLimitQ <= POS_W'(`DGO_LIMIT_RESET);
      irqEnableQ  <= '0;
    end else if (accept && write) begin
      if (address == `DGO_OFF_BOUND_LIMIT) begin
        boundLimitQ <= writedata[POS_W-1:0];
      end
      if (address == `DGO_OFF_TRACK_LIMIT) begin
        trackLimitQ <= writedata[POS_W-1:0];
      end
      if (address == `DGO_OFF_IRQ_ENABLE) begin
        irqEnableQ <= writedata[NUM_OUT-1:0];
      end
    end
  end

  // Millisecond tick. The count is a parameter so a bench can shorten it.
  // The tick runs free, so a delay of D waits between D-1 and D periods;
  // a prescaler per terminal would buy exactness at the cost of a counter.
  logic [TICK_W-1:0] tickCountQ;
  logic              msTickQ;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tickCountQ <= '0;
      msTickQ    <= 1'b0;
    end else if (tickCountQ == TICK_W'(TICK_CYCLES - 1)) begin
      tickCountQ <= '0;
      msTickQ    <= 1'b1;
    end else begin
      tickCountQ <= tickCountQ + 1'b1;
      msTickQ    <= 1'b0;
    end
  end

  // The supply presence comes straight from a pin.
  // Only the second stage is read by the logic behind it.
  logic extSync1Q;
  logic extSync2Q;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      extSync1Q <= 1'b0;
      extSync2Q <= 1'b0;
    end else begin
      extSync1Q <= externalSupplyPresence;
      extSync2Q <= extSync1Q;
    end
  end

  // Position error flags, registered so the wide subtractors do not sit
  // in front of the source mux.
  // The most negative difference keeps its top bit after negation and so
  // reads as a large error, which errs on the safe side.
  logic [POS_W-1:0] posDiff;
  logic [POS_W-1:0] trackDiff;
  logic             boundErrQ;
  logic             trackErrQ;

  always_comb begin
    posDiff = targetPosition - actualPosition;
    if (posDiff[POS_W-1]) begin
      posDiff = POS_W'(0) - posDiff;
    end
    trackDiff = refPulseCount - feedbackPulseCount;
    if (trackDiff[POS_W-1]) begin
      trackDiff = POS_W'(0) - trackDiff;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      boundErrQ <= 1'b0;
      trackErrQ <= 1'b0;
    end else begin
      boundErrQ <= positionDone && (posDiff > boundLimitQ);
      trackErrQ <= trackDiff > trackLimitQ;
    end
  end

  // Per terminal: settings, source mux, delay filter, polarity.
  // Everything in this loop repeats once per terminal; terminals share the bus, the millisecond tick and the condition inputs.
  logic [NUM_OUT-1:0] condSel;
  logic [NUM_OUT-1:0] filtered;
  logic [NUM_OUT-1:0] termD;

  for (genvar i = 0; i < NUM_OUT; i++) begin : g_term
    localparam logic [7:0] BASE =
      8'(`DGO_TERM_BASE + i * `DGO_TERM_STRIDE);

    logic selWr;
    logic onWr;
    logic offWr;
    logic polWr;

    assign selWr = accept && write && address == BASE + `DGO_TOFF_SELECT;
    assign onWr  = accept && write && address == BASE + `DGO_TOFF_ON_DELAY;
    assign offWr = accept && write && address == BASE + `DGO_TOFF_OFF_DELAY;
    assign polWr = accept && write && address == BASE + `DGO_TOFF_POLARITY;

    always_ff @(posedge clock) begin
      if (!rst_n) begin
        selQ[i]    <= `DGO_SEL_RESET;
        onDlyQ[i]  <= `DGO_DELAY_RESET;
        offDlyQ[i] <= `DGO_DELAY_RESET;
        polQ[i]    <= `DGO_POL_RESET;
      end else begin
        if (selWr) begin
          selQ[i] <= writedata[SEL_W-1:0];
        end
        if (onWr) begin
          onDlyQ[i] <= wrDelay;
        end
        if (offWr) begin
          offDlyQ[i] <= wrDelay;
        end
        if (polWr) begin
          polQ[i] <= writedata[0];
        end
      end
    end

    always_comb begin
      case (dgo_pkg::dgo_src_t'(selQ[i]))
        dgo_pkg::SRC_NONE:          condSel[i] = 1'b0;
        dgo_pkg::SRC_AI_ONE_LOSS:   condSel[i] = analogInputLossWarn[0];
        dgo_pkg::SRC_AI_TWO_LOSS:   condSel[i] = analogInputLossWarn[1];
        dgo_pkg::SRC_AI_THREE_LOSS: condSel[i] = analogInputLossWarn[2];
        dgo_pkg::SRC_EXT_SUPPLY:    condSel[i] = extSync2Q;
        dgo_pkg::SRC_CAP_REPLACE:   condSel[i] = capReplaceWarning;
        dgo_pkg::SRC_PRI_FAN_REPL:  condSel[i] = primaryFanReplaceWarning;
        dgo_pkg::SRC_SEC_FAN_REPL:  condSel[i] = secondaryFanReplaceWarning;
        dgo_pkg::SRC_CAP_LIFE:      condSel[i] = capacitorLifeAlarm;
        dgo_pkg::SRC_POS_BOUND_ERR: condSel[i] = boundErrQ;
        dgo_pkg::SRC_POS_TRACK_ERR: condSel[i] = trackErrQ;
        // Codes outside the implemented set drive nothing, like selection 0.
        default:                    condSel[i] = 1'b0;
      endcase
    end

    // The filter runs on the selected condition, so changing a terminal's
    // source in the middle of a wait clears its timer only if the new source
    // already equals the filtered value; otherwise the count runs on.
    dgo_delay_filter #(
      .DELAY_W (DLY_W)
    ) u_filter (
      .clock    (clock),
      .rst_n    (rst_n),
      .msTick   (msTickQ),
      .condIn   (condSel[i]),
      .onDelay  (onDlyQ[i]),
      .offDelay (offDlyQ[i]),
      .filtQ    (filtered[i])
    );

    // Normally open passes the filtered value; normally closed inverts it.
    assign termD[i] = filtered[i] ^ polQ[i];
  end

  // The registered state is both the pin and the readback, so the state
  // read shows the pin as it stood in the cycle before waitrequest went low.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      termQ <= '0;
    end else begin
      termQ <= termD;
    end
  end

  assign terminalOut = termQ;

  // Interrupt: each change of a terminal state sets its sticky bit. A
  // change in the same cycle as a clear keeps the bit set.
  logic [NUM_OUT-1:0] clearMask;
  logic [NUM_OUT-1:0] irqStatusD;

  assign clearMask = (accept && write && address == `DGO_OFF_IRQ_CLEAR)
                     ? writedata[NUM_OUT-1:0] : '0;
  assign irqStatusD = (irqStatusQ & ~clearMask) | (termD ^ termQ);

  // The level follows the next status, so it rises with its sticky bit.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      irqStatusQ <= '0;
      irq        <= 1'b0;
    end else begin
      irqStatusQ <= irqStatusD;
      irq        <= |(irqStatusD & irqEnableQ);
    end
  end

endmodule : dgo_output_cond

`default_nettype wire

//--- rtl/dgo_cfg.svh
/*
  Constants of the digital output conditioning block: register offsets,
  field widths, reset values and the millisecond tick count.
  Assumes byte addresses on a 32-bit register bus, one word per register.
*/
`ifndef DGO_CFG_SVH
`define DGO_CFG_SVH

`define DGO_ADDR_W          8
`define DGO_OFF_STATE       8'h00
`define DGO_OFF_IRQ_STATUS  8'h04
`define DGO_OFF_IRQ_CLEAR   8'h08
`define DGO_OFF_IRQ_ENABLE  8'h0c
`define DGO_OFF_BOUND_LIMIT 8'h10
`define DGO_OFF_TRACK_LIMIT 8'h14
`define DGO_TERM_BASE       8'h20
`define DGO_TERM_STRIDE     8'h10
`define DGO_TOFF_SELECT     8'h00
`define DGO_TOFF_ON_DELAY   8'h04
`define DGO_TOFF_OFF_DELAY  8'h08
`define DGO_TOFF_POLARITY   8'h0c

`define DGO_SEL_W           6
`define DGO_DELAY_W         17
`define DGO_DELAY_MAX_MS    17'h186a0
`define DGO_SEL_RESET       6'h00
`define DGO_DELAY_RESET     17'h00000
`define DGO_POL_RESET       1'b0
`define DGO_LIMIT_RESET     32'h00000000

`define DGO_CLK_PERIOD_PS   5000
`define DGO_TICK_PS         1000000000
`define DGO_TICK_CYCLES     (`DGO_TICK_PS / `DGO_CLK_PERIOD_PS)

`endif

//--- rtl/dgo_pkg.sv
/*
  Types of the digital output conditioning block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package dgo_pkg;

  typedef enum logic [5:0] {
    SRC_NONE          = 6'h00,
    SRC_AI_ONE_LOSS   = 6'h24,
    SRC_AI_TWO_LOSS   = 6'h25,
    SRC_AI_THREE_LOSS = 6'h26,
    SRC_EXT_SUPPLY    = 6'h27,
    SRC_CAP_REPLACE   = 6'h28,
    SRC_PRI_FAN_REPL  = 6'h29,
    SRC_SEC_FAN_REPL  = 6'h2a,
    SRC_CAP_LIFE      = 6'h2b,
    SRC_POS_BOUND_ERR = 6'h2c,
    SRC_POS_TRACK_ERR = 6'h2d
  } dgo_src_t;

endpackage : dgo_pkg

//--- rtl/dgo_delay_filter.sv
/*
  One terminal's turn-on and turn-off delay filter, counted in
  millisecond ticks. Assumes the tick is a one-cycle pulse on the same
  clock and that the delays are stable or change only between edges.
*/
`timescale 1ns/1ps
`default_nettype none

module dgo_delay_filter #(
  parameter int DELAY_W = 17
) (
  input  wire logic               clock,
  input  wire logic               rst_n,
  input  wire logic               msTick,
  input  wire logic               condIn,
  input  wire logic [DELAY_W-1:0] onDelay,
  input  wire logic [DELAY_W-1:0] offDelay,
  output logic                    filtQ
);

  logic [DELAY_W-1:0] countQ;
  logic [DELAY_W-1:0] delaySel;

  assign delaySel = condIn ? onDelay : offDelay;

  // A condition that falls back to the filtered value clears the count,
  // so any change during timing starts the wait over.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      countQ <= '0;
      filtQ  <= 1'b0;
    end else if (condIn == filtQ) begin
      countQ <= '0;
    end else if (delaySel == '0) begin
      filtQ  <= condIn;
      countQ <= '0;
    end else if (msTick) begin
      if (countQ + 1'b1 >= delaySel) begin
        filtQ  <= condIn;
        countQ <= '0;
      end else begin
        countQ <= countQ + 1'b1;
      end
    end
  end

endmodule : dgo_delay_filter

`default_nettype wire

//--- tb/dgo_output_cond_props.sv
/*
  Port checker of the output conditioning block.
  Assumes it is bound to every dgo_output_cond instance.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dgo_cfg.svh"

module dgo_output_cond_props #(
  parameter int NUM_OUT = 3
) (
  input wire logic                   clock,
  input wire logic                   rst_n,
  input wire logic [`DGO_ADDR_W-1:0] address,
  input wire logic                   read,
  input wire logic                   write,
  input wire logic [31:0]            writedata,
  input wire logic [31:0]            readdata,
  input wire logic                   waitrequest,
  input wire logic                   irq,
  input wire logic [NUM_OUT-1:0]     terminalOut
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  property p_reset_out;
    disable iff (1'b0)
    !rst_n |=> waitrequest && !irq && !(|terminalOut) && readdata == 32'h0;
  endproperty
  a_reset_out: assert property (p_reset_out)
    else $error("outputs not cleared by reset");
  property p_wait_answer;
    $rose(read || write) |=> !waitrequest;
  endproperty
  a_wait_answer: assert property (p_wait_answer)
    else $error("no answer one cycle after request");
  property p_wait_single;
    $fell(waitrequest) |=> waitrequest;
  endproperty
  a_wait_single: assert property (p_wait_single)
    else $error("waitrequest low for more than one cycle");
  property p_wait_cause;
    !waitrequest |-> read || write;
  endproperty
  a_wait_cause: assert property (p_wait_cause)
    else $error("answer without request");
  property p_read_stands;
    waitrequest |-> $stable(readdata);
  endproperty
  a_read_stands: assert property (p_read_stands)
    else $error("readdata changed outside an access");
  property p_clear_zero;
    read && !waitrequest && address == `DGO_OFF_IRQ_CLEAR |-> readdata == 32'h0;
  endproperty
  a_clear_zero: assert property (p_clear_zero)
    else $error("clear register read not zero");
  property p_state_read;
    read && !waitrequest && address == `DGO_OFF_STATE && $stable(terminalOut)
      |-> readdata == 32'(terminalOut);
  endproperty
  a_state_read: assert property (p_state_read)
    else $error("state read differs from terminals");
  property p_irq_off;
    write && !waitrequest && address == `DGO_OFF_IRQ_ENABLE &&
      writedata == 32'h0 |-> ##2 !irq;
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("irq high after all sources masked");
endmodule : dgo_output_cond_props

bind dgo_output_cond dgo_output_cond_props #(
  .NUM_OUT(NUM_OUT)
) dgo_output_cond_props_i (
  .clock      (clock),
  .rst_n      (rst_n),
  .address    (address),
  .read       (read),
  .write      (write),
  .writedata  (writedata),
  .readdata   (readdata),
  .waitrequest(waitrequest),
  .irq        (irq),
  .terminalOut(terminalOut)
);
`default_nettype wire

//--- tb/dgo_relay_model.sv
/*
  Relay wired to each output terminal; the contact follows the coil
  one cycle late. Assumes the bench's clock and reset.
*/
`timescale 1ns/1ps
`default_nettype none

module dgo_relay_model #(
  parameter int NUM_OUT = 3
) (
  input  wire logic               clock,
  input  wire logic               rst_n,
  input  wire logic [NUM_OUT-1:0] terminalOut,
  output logic      [NUM_OUT-1:0] contactClosed
);
  // A real armature lags its coil, so the contact is never the same cycle.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      contactClosed <= '0;
    end else begin
      contactClosed <= terminalOut;
    end
  end
endmodule : dgo_relay_model
`default_nettype wire

//--- tb/testbench.sv
/*
  Self-checking bench of the output conditioning block with relay model.
  Assumes design, checker and relay model are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dgo_cfg.svh"

module testbench;
  localparam int TICK = 10;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  address = 8'h00;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata, rdv, r;
  logic        waitrequest, irq, e;
  logic [2:0]  terminalOut, contactClosed;
  logic [2:0]  aiLoss = 3'h0;
  // Bits: supply, capacitor, primary fan, secondary fan, life, done.
  logic [5:0]  flags = 6'h00;
  logic [5:0]  sel;
  logic [31:0] tgt = 32'h0, act = 32'h0, refCnt = 32'h0, fbCnt = 32'h0;
  int          error_cnt = 0;
  int          n_compared = 0;
  int          seed = 32'hc0c4b1c1;
  int          n;

  always #2.5 clock = ~clock;

  dgo_output_cond #(.TICK_CYCLES(TICK)) dgo_output_cond_i (
    .clock(clock), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .irq(irq), .terminalOut(terminalOut),
    .analogInputLossWarn(aiLoss), .externalSupplyPresence(flags[0]),
    .capReplaceWarning(flags[1]), .primaryFanReplaceWarning(flags[2]),
    .secondaryFanReplaceWarning(flags[3]), .capacitorLifeAlarm(flags[4]),
    .positionDone(flags[5]), .targetPosition(tgt), .actualPosition(act),
    .refPulseCount(refCnt), .feedbackPulseCount(fbCnt));
  dgo_relay_model dgo_relay_model_i (.clock(clock), .rst_n(rst_n),
    .terminalOut(terminalOut), .contactClosed(contactClosed));

  task automatic test_done();
    if (error_cnt == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : test_done

  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // One Avalon access; read data lands in rdv.
  task automatic bus(logic wr, logic [7:0] a, logic [31:0] d);
    int k;
    @(posedge clock);
    address   <= a;
    writedata <= d;
    read      <= !wr;
    write     <= wr;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (waitrequest !== 1'b0 && k < 50);
    if (k >= 50) begin
      error_cnt++;
      test_done();
    end
    rdv = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task automatic wait_term(int b, logic v);
    n = 0;
    while (terminalOut[b] !== v && n < 200) begin
      @(posedge clock);
      n++;
    end
    if (n >= 200) begin
      error_cnt++;
      test_done();
    end
  endtask : wait_term

  function automatic logic [31:0] absdiff(logic [31:0] a, logic [31:0] b);
    logic [31:0] d;
    d = a - b;
    return d[31] ? -d : d;
  endfunction : absdiff

  function automatic logic srcval(logic [5:0] s);
    case (s)
      6'h24, 6'h25, 6'h26: return aiLoss[s - 6'h24];
      6'h27, 6'h28, 6'h29, 6'h2a, 6'h2b: return flags[s - 6'h27];
      6'h2c: return flags[5] && absdiff(tgt, act) > 32'd100;
      6'h2d: return absdiff(refCnt, fbCnt) > 32'd100;
      default: return 1'b0;
    endcase
  endfunction : srcval

  initial begin
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    for (int a = 32; a < 80; a += 4) begin
      bus(1'b0, 8'(a), 32'h0);
      chk("reg reset", 32'h0, rdv);
    end
    bus(1'b1, 8'h18, 32'h5);
    bus(1'b0, 8'h18, 32'h0);
    chk("unmapped", 32'h0, rdv);
    bus(1'b1, 8'h44, 32'h1ffff);
    bus(1'b0, 8'h44, 32'h0);
    chk("clamp", 32'(`DGO_DELAY_MAX_MS), rdv);
    bus(1'b1, 8'h10, 32'd100);
    bus(1'b1, 8'h14, 32'd100);
    for (int i = 0; i < 40; i++) begin
      r = $random(seed);
      sel = 6'(36 + r[15:12] % 10);
      if (i < 10) sel = 6'(36 + i);
      if (i == 10 || i == 11) sel = 6'(i - 10);
      if (i == 12 || i == 13) sel = 6'h2c;
      bus(1'b1, 8'h20, 32'(sel));
      bus(1'b1, 8'h2c, 32'(r[16]));
      @(posedge clock);
      aiLoss <= r[2:0];
      flags  <= (i == 12 || i == 13) ? {1'b1, r[7:3]} : r[8:3];
      tgt    <= r;
      act    <= (i == 12 || i == 13) ? r + 32'(88 + i)
                                     : r + {{24{r[23]}}, r[23:16]};
      refCnt <= ~r;
      fbCnt  <= ~r + {{24{r[31]}}, r[31:24]};
      repeat (8) @(posedge clock);
      bus(1'b0, 8'h00, 32'h0);
      e = srcval(sel) ^ r[16];
      chk("out0", 32'(e), 32'(terminalOut[0]));
      chk("out", 32'(e), 32'(terminalOut));
      chk("state", 32'(e), rdv);
      chk("contact", 32'(e), 32'(contactClosed));
      chk("polarity", 32'(e), 32'(terminalOut[0]));
    end
    bus(1'b1, 8'h20, 32'h0);
    bus(1'b1, 8'h2c, 32'h0);
    bus(1'b1, 8'h30, 32'h28);
    bus(1'b1, 8'h34, 32'd3);
    bus(1'b1, 8'h38, 32'd2);
    bus(1'b1, 8'h0c, 32'h2);
    @(posedge clock);
    flags <= 6'h00;
    repeat (40) @(posedge clock);
    bus(1'b1, 8'h08, 32'h7);
    @(posedge clock);
    flags <= 6'h02;
    repeat (12) @(posedge clock);
    flags <= 6'h00;
    repeat (40) @(posedge clock);
    bus(1'b0, 8'h04, 32'h0);
    chk("short pulse", 32'h0, rdv | 32'(terminalOut[1]));
    @(posedge clock);
    flags <= 6'h02;
    wait_term(1, 1'b1);
    chk("on time", 32'h1, 32'(n >= 2 * TICK && n <= 3 * TICK + 4));
    repeat (3) @(posedge clock);
    chk("irq set", 32'h1, 32'(irq));
    bus(1'b1, 8'h08, 32'h2);
    repeat (3) @(posedge clock);
    chk("irq clear", 32'h0, 32'(irq));
    flags <= 6'h00;
    wait_term(1, 1'b0);
    chk("off time", 32'h1, 32'(n >= TICK && n <= 2 * TICK + 4));
    bus(1'b1, 8'h0c, 32'h0);
    repeat (3) @(posedge clock);
    bus(1'b0, 8'h04, 32'h0);
    chk("masked", 32'h2, rdv | 32'(irq));
    bus(1'b0, 8'h08, 32'h0);
    chk("clear reads zero", 32'h0, rdv);
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    bus(1'b0, 8'h44, 32'h0);
    chk("delay after reset", 32'h0, rdv);
    bus(1'b0, 8'h04, 32'h0);
    chk("status after reset", 32'h0, rdv | 32'(irq));
    test_done();
  end
endmodule : testbench
`default_nettype wire
